// >>> design/esc_cmd.sv
`timescale 1ns/1ps
// Summary of operation
// - Status read 2F returns a byte; bit 5 is high-voltage not ready, reset 0.
// - Status bit 4 shows the supply below its detect threshold, reset 0.
// - Status bit 2 carries busy, but 2F is only decoded while idle, so bits 2 and 3 always read 0.
// - Status bits 1:0 carry a fixed two-bit chip identity code.
// - Bits 5 and 4 are refreshed only when commands 14 and 15 run.
// - Busy stays high for the whole waveform programming run, then drops.
// - Command 32 takes 153 bytes, stored in order into the waveform table.
// - Command 39 sets program mode from bits 1:0; 00 normal at reset, 11 internal voltage.
// - Command 3C sets the border byte; reset C0 leaves the border floating.
// - Border bits 7:6 pick gray transition, fixed level, common electrode or floating.
// - With fixed level, bits 5:4 pick ground or the first positive source level.
// - With gray transition, bits 1:0 pick table waveform 0 to 3.
module esc_cmd
  import esc_pkg::*;
#(
  parameter logic [1:0] CHIP_ID = 2'h2
) (
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  input wire logic sclk_i,
  input wire logic cs_n_i,
  input wire logic dc_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  input wire logic internal_clock_enable_i,
  input wire logic high_voltage_rail_ready_i,
  input wire logic supply_input_level_low_i,
  output logic busy_o,
  output logic ram_rd_o,
  output logic [LUT_AW-1:0] ram_addr_o,
  input wire logic [7:0] ram_data_i,
  output logic otp_we_o,
  output logic [LUT_AW-1:0] otp_addr_o,
  output logic [7:0] otp_data_o,
  output logic [1:0] otp_mode_o,
  input wire logic [LUT_AW-1:0] lut_rd_addr_i,
  output logic [7:0] lut_rd_data_o,
  output logic [7:0] border_cfg_o,
  output logic [1:0] border_src_o,
  output logic [1:0] border_level_o,
  output logic [1:0] border_lut_o,
  output logic border_high_impedance_o
);
  // CHIP_ID is an arbitrary neutral value for the identity field.

  typedef enum logic [2:0] {
    S_IDLE,
    S_READ,
    S_LATCH,
    S_WRITE,
    S_WAIT
  } esc_otp_state_t;

  localparam logic [15:0] WAIT_LAST = 16'(OTP_BYTE_CYC - 1);

  // Byte path from the serial front end through the queue.
  logic rx_valid, rx_ready;
  logic [FIFO_W-1:0] rx_data;
  logic q_valid;
  logic [FIFO_W-1:0] q_data;
  logic rd_load;
  logic [7:0] status_byte;

  // Decoder state.
  logic [7:0] cur_cmd_r;
  logic [7:0] param_idx_r;
  logic rail_not_ready_r;
  logic supply_low_r;
  logic [7:0] otp_mode_r;
  logic [7:0] border_r;
  logic border_float_r;
  logic [1:0] border_level_r;
  logic [1:0] border_lut_r;
  logic [7:0] lut_mem_r [LUT_BYTES];
  logic [7:0] lut_rd_r;

  // Level inputs from the analog side.
  logic [1:0] rail_s_r;
  logic [1:0] supply_s_r;

  // Programming sequencer.
  esc_otp_state_t state_r, state_nxt;
  logic [LUT_AW-1:0] otp_idx_r;
  logic [7:0] otp_data_r;
  logic [15:0] wait_cnt_r;

  // The queue is drained only while the sequencer is idle, so programming
  // holds back up to four later bytes there and one more at the link; any further byte overwrites that one.
  wire prog_idle = (state_r == S_IDLE);
  wire pop_ready = prog_idle;

  // One command strobe: the head byte is a command and matches the code.
  function automatic logic cmd_is(input logic cmd_pop, input logic [7:0] b, input logic [7:0] code);
    return cmd_pop & (b == code);
  endfunction : cmd_is

  // Border decode into float flag, fixed level and gray table. It serves both
  // the reset value and the write path, so the two can never disagree.
  function automatic logic [4:0] bd_decode(input logic [7:0] b);
    logic [1:0] src;
    src = b[BD_SRC_MSB:BD_SRC_LSB];
    return {src == BD_SRC_FLOAT, (src == BD_SRC_FIXED) ? b[BD_LVL_MSB:BD_LVL_LSB] : 2'h0,
      (src == BD_SRC_GRAY) ? b[BD_LUT_MSB:BD_LUT_LSB] : 2'h0};
  endfunction : bd_decode

  // Serial front end: sampling of the link pins and the read-back shifter.
  esc_spi_if u_spi (
    .clk_sys_i(clk_sys_i),
    .rstn_i(rstn_i),
    .sclk_i(sclk_i),
    .cs_n_i(cs_n_i),
    .dc_i(dc_i),
    .sda_i(sda_i),
    .sda_o(sda_o),
    .sda_oe_o(sda_oe_o),
    .byte_valid_o(rx_valid),
    .byte_ready_i(rx_ready),
    .byte_data_o(rx_data),
    .rd_load_i(rd_load),
    .rd_data_i(status_byte)
  );

  // The queue absorbs bytes that arrive while programming holds the decoder.
  esc_fifo #(
    .W(FIFO_W),
    .D(FIFO_D)
  ) u_fifo (
    .clk_sys_i(clk_sys_i),
    .rstn_i(rstn_i),
    .in_valid_i(rx_valid),
    .in_ready_o(rx_ready),
    .in_data_i(rx_data),
    .out_valid_o(q_valid),
    .out_ready_i(pop_ready),
    .out_data_o(q_data)
  );

  // Decoding of the byte at the head of the queue.
  wire pop = q_valid & pop_ready;
  wire [7:0] q_byte = q_data[7:0];
  wire is_cmd = pop & ~q_data[8];
  wire is_param = pop & q_data[8];
  wire first_param = is_param & (param_idx_r == 8'h00);

  // The table index is checked here, so bytes past the last one never reach storage.
  wire lut_wr = is_param & (cur_cmd_r == CMD_LUT_WRITE) & (param_idx_r <= LUT_LAST);

  // Single-byte settings take only the first parameter after their command.
  wire mode_wr = first_param & (cur_cmd_r == CMD_OTP_MODE);
  wire border_wr = first_param & (cur_cmd_r == CMD_BORDER);

  // Command strobes, one clock wide, as the command byte leaves the queue.
  wire rail_cmd = cmd_is(is_cmd, q_byte, CMD_RAIL_DETECT);
  wire supply_cmd = cmd_is(is_cmd, q_byte, CMD_SUPPLY_DETECT);
  // Without the internal clock the sequencer has nothing to run on, so the
  // start is refused rather than left hanging with busy high.
  wire otp_start = cmd_is(is_cmd, q_byte, CMD_OTP_PROGRAM) & internal_clock_enable_i;
  assign rd_load = cmd_is(is_cmd, q_byte, CMD_STATUS_READ);

  // The status byte is assembled live, so busy is current when it is loaded.
  always_comb begin
    status_byte = '0;
    status_byte[ST_RAIL_BIT] = rail_not_ready_r;
    status_byte[ST_SUPPLY_BIT] = supply_low_r;
    status_byte[ST_RSV_BIT] = 1'b0;
    status_byte[ST_BUSY_BIT] = busy_o;
    status_byte[ST_ID_MSB:ST_ID_LSB] = CHIP_ID;
  end

  // Analog level inputs come from outside the clock domain.
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      rail_s_r <= '0;
      supply_s_r <= '0;
    end else begin
      rail_s_r <= {rail_s_r[0], high_voltage_rail_ready_i};
      supply_s_r <= {supply_s_r[0], supply_input_level_low_i};
    end
  end

  // The detect flags only move when their own command runs; between runs they
  // hold, even if the supply changes, which is why the host must re-issue them.
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      rail_not_ready_r <= 1'b0;
      supply_low_r <= 1'b0;
    end else begin
      if (rail_cmd) rail_not_ready_r <= ~rail_s_r[1];
      if (supply_cmd) supply_low_r <= supply_s_r[1];
    end
  end

  // Track the latest command and how many parameters have followed it.
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      cur_cmd_r <= '0;
      param_idx_r <= '0;
    end else if (is_cmd) begin
      cur_cmd_r <= q_byte;
      param_idx_r <= '0;
    end else if (is_param && param_idx_r != PARAM_MAX) begin
      param_idx_r <= param_idx_r + 8'h01;
    end
  end

  // Single-byte settings; extra parameters after the first are ignored.
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      otp_mode_r <= OTP_MODE_RST;
      border_r <= BORDER_RST;
      {border_float_r, border_level_r, border_lut_r} <= bd_decode(BORDER_RST);
    end else begin
      if (mode_wr) otp_mode_r <= q_byte;
      if (border_wr) border_r <= q_byte;
      if (border_wr) {border_float_r, border_level_r, border_lut_r} <= bd_decode(q_byte);
    end
  end

  // Table bytes land at their arrival index; bytes past the last are dropped.
  always_ff @(posedge clk_sys_i) begin
    if (lut_wr) begin
      lut_mem_r[param_idx_r] <= q_byte;
    end
  end

  // Table read port for the waveform engine, registered one cycle.
  // Indices past the table read as zero; cells inside it have no reset and read unwritten until command 32 fills them.
  wire lut_rd_ok = (lut_rd_addr_i <= LUT_LAST);
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      lut_rd_r <= '0;
    end else begin
      lut_rd_r <= lut_rd_ok ? lut_mem_r[lut_rd_addr_i] : '0;
    end
  end

  assign lut_rd_data_o = lut_rd_r;
  assign otp_mode_o = otp_mode_r[MODE_MSB:MODE_LSB];

  // Border outputs come straight from flops. Bits 3:2 of the byte are not
  // decoded; they only show on the raw copy.
  wire [1:0] bd_src = border_r[BD_SRC_MSB:BD_SRC_LSB];
  assign border_cfg_o = border_r;
  assign border_src_o = bd_src;
  assign border_high_impedance_o = border_float_r;
  assign border_level_o = border_level_r;
  assign border_lut_o = border_lut_r;

  // Programming walks the display RAM: read, latch, write, settle, per byte.
  // The source must already hold the waveform; nothing here checks it.
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      S_IDLE: begin
        if (otp_start) state_nxt = S_READ;
      end
      S_READ: begin
        state_nxt = S_LATCH;
      end
      S_LATCH: begin
        state_nxt = S_WRITE;
      end
      S_WRITE: begin
        state_nxt = S_WAIT;
      end
      S_WAIT: begin
        if (wait_cnt_r == WAIT_LAST) begin
          state_nxt = (otp_idx_r == LUT_LAST) ? S_IDLE : S_READ;
        end
      end
      // A corrupt state code returns to idle rather than leaving busy stuck high.
      default: begin
        state_nxt = S_IDLE;
      end
    endcase
  end

  // Sequencer registers: state, byte index, captured data, settle counter.
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      state_r <= S_IDLE;
      otp_idx_r <= '0;
      otp_data_r <= '0;
      wait_cnt_r <= '0;
    end else begin
      state_r <= state_nxt;
      if (otp_start) otp_idx_r <= '0;
      else if (state_r == S_WAIT && state_nxt == S_READ) otp_idx_r <= otp_idx_r + 1'b1;
      if (state_r == S_LATCH) otp_data_r <= ram_data_i;
      wait_cnt_r <= (state_r == S_WAIT) ? wait_cnt_r + 16'h0001 : '0;
    end
  end

  // Busy covers the whole run, from the cycle after the command to the last settle.
  assign busy_o = ~prog_idle;
  assign ram_rd_o = (state_r == S_READ);
  assign ram_addr_o = otp_idx_r;
  assign otp_we_o = (state_r == S_WRITE);
  assign otp_addr_o = otp_idx_r;
  assign otp_data_o = otp_data_r;

endmodule : esc_cmd

// >>> design/esc_fifo.sv
`timescale 1ns/1ps
module esc_fifo #(
  parameter int unsigned W = 9,
  parameter int unsigned D = 4
) (
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [W-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [W-1:0] out_data_o
);

  localparam int unsigned AW = (D > 1) ? $clog2(D) : 1;
  localparam logic [AW:0] DEPTH = (AW + 1)'(D);
  localparam logic [AW-1:0] LAST = (AW)'(D - 1);

  logic [W-1:0] mem_r [D];
  logic [AW-1:0] wr_ptr_r;
  logic [AW-1:0] rd_ptr_r;
  logic [AW:0] count_r;

  // Full and empty come straight from the occupancy count.
  wire push = in_valid_i & in_ready_o;
  wire pop = out_valid_o & out_ready_i;
  assign in_ready_o = (count_r != DEPTH);
  assign out_valid_o = (count_r != '0);
  assign out_data_o = mem_r[rd_ptr_r];

  // Storage is written only at the write pointer, so it needs no reset.
  always_ff @(posedge clk_sys_i) begin
    if (push) begin
      mem_r[wr_ptr_r] <= in_data_i;
    end
  end

  // Pointers wrap at the depth, which need not be a power of two.
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= '0;
    end else begin
      if (push) wr_ptr_r <= (wr_ptr_r == LAST) ? '0 : wr_ptr_r + 1'b1;
      if (pop) rd_ptr_r <= (rd_ptr_r == LAST) ? '0 : rd_ptr_r + 1'b1;
      if (push && !pop) count_r <= count_r + 1'b1;
      else if (pop && !push) count_r <= count_r - 1'b1;
    end
  end

endmodule : esc_fifo

// >>> design/esc_pkg.sv
package esc_pkg;

  // Host clock rate.
  localparam int unsigned CLK_PERIOD_NS = 100;

  // Command codes handled by this decoder.
  localparam logic [7:0] CMD_RAIL_DETECT = 8'h14;
  localparam logic [7:0] CMD_SUPPLY_DETECT = 8'h15;
  localparam logic [7:0] CMD_STATUS_READ = 8'h2f;
  localparam logic [7:0] CMD_OTP_PROGRAM = 8'h30;
  localparam logic [7:0] CMD_LUT_WRITE = 8'h32;
  localparam logic [7:0] CMD_OTP_MODE = 8'h39;
  localparam logic [7:0] CMD_BORDER = 8'h3c;

  // Waveform table geometry.
  localparam int unsigned LUT_BYTES = 153;
  localparam int unsigned LUT_AW = 8;
  localparam logic [LUT_AW-1:0] LUT_LAST = 8'h98;
  localparam logic [7:0] PARAM_MAX = 8'hff;

  // Reset values of the writable settings.
  localparam logic [7:0] OTP_MODE_RST = 8'h00;
  localparam logic [7:0] BORDER_RST = 8'hc0;

  // Status byte layout.
  localparam int unsigned ST_RAIL_BIT = 5;
  localparam int unsigned ST_SUPPLY_BIT = 4;
  localparam int unsigned ST_RSV_BIT = 3;
  localparam int unsigned ST_BUSY_BIT = 2;
  localparam int unsigned ST_ID_MSB = 1;
  localparam int unsigned ST_ID_LSB = 0;

  // Program mode and border fields.
  localparam int unsigned MODE_MSB = 1;
  localparam int unsigned MODE_LSB = 0;
  localparam int unsigned BD_SRC_MSB = 7;
  localparam int unsigned BD_SRC_LSB = 6;
  localparam int unsigned BD_LVL_MSB = 5;
  localparam int unsigned BD_LVL_LSB = 4;
  localparam int unsigned BD_LUT_MSB = 1;
  localparam int unsigned BD_LUT_LSB = 0;

  // Border source encodings, in field order.
  typedef enum logic [1:0] {
    BD_SRC_GRAY,
    BD_SRC_FIXED,
    BD_SRC_COMMON,
    BD_SRC_FLOAT
  } esc_border_src_t;

  // Serial link and byte queue.
  localparam int unsigned SPI_BITS = 8;
  localparam int unsigned FIFO_W = 9;
  localparam int unsigned FIFO_D = 4;

  // Time taken to burn one table byte into one-time memory.
  localparam int unsigned OTP_BYTE_TIME_NS = 10000;
  localparam int unsigned OTP_BYTE_CYC = (OTP_BYTE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage : esc_pkg

// >>> design/esc_spi_if.sv
`timescale 1ns/1ps
module esc_spi_if
  import esc_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  input wire logic sclk_i,
  input wire logic cs_n_i,
  input wire logic dc_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  output logic byte_valid_o,
  input wire logic byte_ready_i,
  output logic [FIFO_W-1:0] byte_data_o,
  input wire logic rd_load_i,
  input wire logic [7:0] rd_data_i
);

  localparam logic [3:0] BITS = 4'(SPI_BITS);

  logic [1:0] sclk_s_r, cs_s_r, dc_s_r, sda_s_r;
  logic sclk_d_r;
  logic [7:0] rx_sh_r, tx_sh_r;
  logic [3:0] rx_cnt_r, tx_cnt_r;
  logic rd_act_r;
  logic [FIFO_W-1:0] hold_r;
  logic hold_v_r;

  // Every pin passes two flops; below, only the second stage is read, plus a third sclk flop for edge detection.
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      sclk_s_r <= '0;
      cs_s_r <= 2'h3;
      dc_s_r <= '0;
      sda_s_r <= '0;
      sclk_d_r <= 1'b0;
    end else begin
      sclk_s_r <= {sclk_s_r[0], sclk_i};
      cs_s_r <= {cs_s_r[0], cs_n_i};
      dc_s_r <= {dc_s_r[0], dc_i};
      sda_s_r <= {sda_s_r[0], sda_i};
      sclk_d_r <= sclk_s_r[1];
    end
  end

  wire sel = ~cs_s_r[1];
  wire rise = sel & sclk_s_r[1] & ~sclk_d_r;
  wire fall = sel & ~sclk_s_r[1] & sclk_d_r;
  wire rx_done = rise & ~rd_act_r & (rx_cnt_r == BITS - 4'h1);

  // Bytes are taken MSB first on rising edges, tagged with the data/command level.
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i || !sel) begin
      rx_cnt_r <= '0;
      rx_sh_r <= '0;
    end else if (rise && !rd_act_r) begin
      rx_sh_r <= {rx_sh_r[6:0], sda_s_r[1]};
      rx_cnt_r <= rx_done ? '0 : rx_cnt_r + 4'h1;
    end
  end

  // The link cannot be stalled, so a finished byte waits here; a second byte
  // finishing while the queue stays full replaces it.
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      hold_v_r <= 1'b0;
      hold_r <= '0;
    end else if (rx_done) begin
      hold_v_r <= 1'b1;
      hold_r <= {dc_s_r[1], rx_sh_r[6:0], sda_s_r[1]};
    end else if (byte_ready_i) begin
      hold_v_r <= 1'b0;
    end
  end

  assign byte_valid_o = hold_v_r;
  assign byte_data_o = hold_r;

  // Read-back shifts MSB first, one bit per falling edge, for one byte.
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      rd_act_r <= 1'b0;
      tx_sh_r <= '0;
      tx_cnt_r <= '0;
    end else if (rd_load_i) begin
      rd_act_r <= 1'b1;
      tx_sh_r <= rd_data_i;
      tx_cnt_r <= '0;
    end else if (!sel) begin
      rd_act_r <= 1'b0;
    end else if (fall && rd_act_r) begin
      tx_sh_r <= {tx_sh_r[6:0], 1'b0};
      tx_cnt_r <= tx_cnt_r + 4'h1;
      if (tx_cnt_r == BITS - 4'h1) rd_act_r <= 1'b0;
    end
  end

  assign sda_o = tx_sh_r[7];
  assign sda_oe_o = rd_act_r & sel;

endmodule : esc_spi_if

// >>> verif/esc_cmd_asserts.sv
`timescale 1ns/1ps
module esc_cmd_asserts
  import esc_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  input wire logic busy_o,
  input wire logic ram_rd_o,
  input wire logic [LUT_AW-1:0] ram_addr_o,
  input wire logic otp_we_o,
  input wire logic [LUT_AW-1:0] otp_addr_o,
  input wire logic [1:0] otp_mode_o,
  input wire logic [7:0] border_cfg_o,
  input wire logic [1:0] border_src_o,
  input wire logic [1:0] border_level_o,
  input wire logic [1:0] border_lut_o,
  input wire logic border_high_impedance_o,
  input wire logic sda_oe_o
);
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!rstn_i);

  chk_reset_values: assert property ($rose(rstn_i) |-> border_cfg_o == BORDER_RST && otp_mode_o == 2'h0)
    else $error("settings not at reset values");
  chk_src_field: assert property (border_src_o == border_cfg_o[7:6])
    else $error("border source differs from its field");
  chk_float_src: assert property (border_high_impedance_o == (border_src_o == 2'h3))
    else $error("high impedance flag wrong");
  chk_fixed_level: assert property (border_level_o == ((border_src_o == 2'h1) ? border_cfg_o[5:4] : 2'h0))
    else $error("border level wrong");
  chk_gray_table: assert property (border_lut_o == ((border_src_o == 2'h0) ? border_cfg_o[1:0] : 2'h0))
    else $error("border table select wrong");
  chk_busy_start: assert property ($rose(busy_o) |-> ram_rd_o && ram_addr_o == 8'h00)
    else $error("programming did not start at byte zero");
  chk_write_after_read: assert property (ram_rd_o |-> ##2 otp_we_o && busy_o)
    else $error("memory write did not follow read");
  chk_read_spacing: assert property (ram_rd_o |=> !ram_rd_o [*8])
    else $error("reads too close together");
  chk_write_index: assert property (otp_we_o |-> otp_addr_o == $past(ram_addr_o, 2))
    else $error("write index differs from read index");
  chk_busy_end: assert property ($fell(busy_o) |-> otp_addr_o == LUT_LAST)
    else $error("busy dropped before the last byte");

  cover property ($rose(busy_o));
  cover property (border_src_o == 2'h1);
  cover property ($fell(sda_oe_o));
endmodule : esc_cmd_asserts

bind esc_cmd esc_cmd_asserts i_chk (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .busy_o(busy_o), .ram_rd_o(ram_rd_o),
  .ram_addr_o(ram_addr_o), .otp_we_o(otp_we_o), .otp_addr_o(otp_addr_o), .otp_mode_o(otp_mode_o),
  .border_cfg_o(border_cfg_o), .border_src_o(border_src_o), .border_level_o(border_level_o),
  .border_lut_o(border_lut_o), .border_high_impedance_o(border_high_impedance_o), .sda_oe_o(sda_oe_o));

// >>> verif/esc_cmd_tb.sv
`timescale 1ns/1ps
module esc_cmd_tb;
  import esc_pkg::*;
  localparam logic [1:0] CHIP_ID = 2'h2; // Arbitrary identity value.
  logic clk_sys_i = 1'b0;
  logic rstn_i = 1'b0;
  logic sclk, cs_n, dc, host_sda, sda_out, sda_oe, sda_w, busy, ram_rd, otp_we, b_float, s;
  logic clk_en = 1'b0;
  logic rail_rdy = 1'b1;
  logic sup_low = 1'b0;
  logic [7:0] ram_addr, otp_addr, otp_data, lut_data, bcfg, st;
  logic [7:0] lut_addr = 8'h00;
  logic [7:0] ram_data = 8'h00;
  logic [7:0] n_we = 8'h00;
  logic [1:0] mode, bsrc, blvl, blut;
  logic [7:0] bd_in [4] = '{8'h23, 8'h53, 8'hb1, 8'hc0};
  logic [7:0] bd_exp [4] = '{8'h0c, 8'h50, 8'h80, 8'hc2};
  int n_errors = 0;
  int n_checks = 0;
  int k;

  always #50 clk_sys_i = ~clk_sys_i;
  // The device wins the shared data line whenever it drives it.
  assign sda_w = sda_oe ? sda_out : host_sda;

  esc_host_model i_host (.clk_sys_i(clk_sys_i), .sda_i(sda_w), .sclk_o(sclk), .cs_n_o(cs_n), .dc_o(dc),
    .sda_o(host_sda));
  esc_cmd #(.CHIP_ID(CHIP_ID)) i_dut (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .sclk_i(sclk), .cs_n_i(cs_n),
    .dc_i(dc), .sda_i(sda_w), .sda_o(sda_out), .sda_oe_o(sda_oe), .internal_clock_enable_i(clk_en),
    .high_voltage_rail_ready_i(rail_rdy), .supply_input_level_low_i(sup_low), .busy_o(busy), .ram_rd_o(ram_rd),
    .ram_addr_o(ram_addr), .ram_data_i(ram_data), .otp_we_o(otp_we), .otp_addr_o(otp_addr),
    .otp_data_o(otp_data), .otp_mode_o(mode), .lut_rd_addr_i(lut_addr), .lut_rd_data_o(lut_data),
    .border_cfg_o(bcfg), .border_src_o(bsrc), .border_level_o(blvl), .border_lut_o(blut),
    .border_high_impedance_o(b_float));

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic cmd(input logic [7:0] c);
    i_host.send(1'b0, c, 4, s);
    i_host.done();
  endtask : cmd
  task automatic cmd_par(input logic [7:0] c, input logic [7:0] p);
    i_host.send(1'b0, c, 4, s);
    i_host.send(1'b1, p, 4, s);
    i_host.done();
    repeat (10) @(negedge clk_sys_i);
  endtask : cmd_par
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : tally_and_finish

  // Display memory model: the byte is ready the cycle after each read.
  always @(negedge clk_sys_i) begin
    if (ram_rd) begin
      ram_data <= ram_addr ^ 8'h3c;
    end
    if (otp_we) begin
      check(otp_addr, n_we);
      check(otp_data, n_we ^ 8'h3c);
      n_we <= n_we + 8'h01;
    end
  end

  // The budget allows the whole sequence nearly three times over.
  initial begin
    repeat (80000) @(negedge clk_sys_i);
    n_errors++;
    $display("watchdog expired at %0t", $time);
    tally_and_finish();
  end

  initial begin
    repeat (20) @(negedge clk_sys_i);
    rstn_i = 1'b1;
    repeat (4) @(negedge clk_sys_i);
    check(bcfg, BORDER_RST);
    check({6'h0, mode}, OTP_MODE_RST);
    i_host.read_status(st);
    check(st, {6'h0, CHIP_ID});
    $display("test reset finished");
    rail_rdy = 1'b0;
    sup_low = 1'b1;
    i_host.read_status(st);
    check(st, {6'h0, CHIP_ID});
    cmd(CMD_RAIL_DETECT);
    cmd(CMD_SUPPLY_DETECT);
    i_host.read_status(st);
    check(st, {4'h3, 2'h0, CHIP_ID});
    rail_rdy = 1'b1;
    sup_low = 1'b0;
    cmd(CMD_RAIL_DETECT);
    cmd(CMD_SUPPLY_DETECT);
    i_host.read_status(st);
    check(st, {6'h0, CHIP_ID});
    $display("test status finished");
    cmd_par(CMD_OTP_MODE, 8'h03);
    check({6'h0, mode}, 8'h03);
    cmd_par(CMD_OTP_MODE, 8'hfc);
    check({6'h0, mode}, 8'h00);
    for (int i = 0; i < 4; i++) begin
      cmd_par(CMD_BORDER, bd_in[i]);
      check(bcfg, bd_in[i]);
      check({bsrc, blvl, blut, b_float, 1'b0}, bd_exp[i]);
    end
    $display("test mode and border finished");
    i_host.send(1'b0, CMD_LUT_WRITE, 4, s);
    for (int i = 0; i < LUT_BYTES; i++) begin
      i_host.send(1'b1, i[7:0] ^ 8'h5a, 4, s);
    end
    i_host.done();
    repeat (10) @(negedge clk_sys_i);
    for (int i = 0; i <= LUT_BYTES; i++) begin
      lut_addr = i[7:0];
      @(negedge clk_sys_i);
      check(lut_data, (i < LUT_BYTES) ? (i[7:0] ^ 8'h5a) : 8'h00);
    end
    $display("test table finished");
    cmd(CMD_OTP_PROGRAM);
    repeat (200) @(negedge clk_sys_i);
    check({busy, n_we[6:0]}, 8'h00);
    clk_en = 1'b1;
    cmd(CMD_OTP_PROGRAM);
    k = 0;
    while (busy !== 1'b0 && k < 17000) begin
      @(negedge clk_sys_i);
      k++;
    end
    check(n_we, 8'h99);
    check({7'h0, busy}, 8'h00);
    $display("test programming finished");
    tally_and_finish();
  end
endmodule : esc_cmd_tb

// >>> verif/esc_host_model.sv
`timescale 1ns/1ps
module esc_host_model
  import esc_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic sda_i,
  output logic sclk_o,
  output logic cs_n_o,
  output logic dc_o,
  output logic sda_o
);
  logic rel = 1'b1;
  logic bit_r = 1'b0;
  logic noise = 1'b0;
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    dc_o = 1'b0;
  end
  // A released line toggles every cycle, so a stale level never passes for data.
  always @(negedge clk_sys_i) begin
    noise <= ~noise;
  end
  assign sda_o = rel ? noise : bit_r;
  // One bit: data set while the clock is low, line sampled just before the fall.
  task automatic clk_bit(input logic b, input int hi, output logic s);
    bit_r = b;
    repeat (4) @(negedge clk_sys_i);
    sclk_o = 1'b1;
    repeat (hi) @(negedge clk_sys_i);
    s = sda_i;
    sclk_o = 1'b0;
  endtask : clk_bit
  // A whole byte, MSB first, marked command or parameter.
  task automatic send(input logic is_data, input logic [7:0] b, input int tail, output logic s);
    cs_n_o = 1'b0;
    dc_o = is_data;
    rel = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      clk_bit(b[i], (i == 0) ? tail : 4, s);
    end
  endtask : send
  // The line is released when the frame closes; a status read releases it earlier, after the command byte.
  task automatic done();
    repeat (4) @(negedge clk_sys_i);
    cs_n_o = 1'b1;
    rel = 1'b1;
    repeat (4) @(negedge clk_sys_i);
  endtask : done
  // The long last high lets the device load bit 7 before the first fall.
  task automatic read_status(output logic [7:0] v);
    logic s;
    send(1'b0, CMD_STATUS_READ, 12, s);
    rel = 1'b1;
    v[7] = s;
    for (int i = 6; i >= 0; i--) begin
      clk_bit(1'b0, 4, s);
      v[i] = s;
    end
    done();
  endtask : read_status
endmodule : esc_host_model
